// *** include/tpu_pkg.sv ***
// Shared constants for the timer compare/PWM channels.
// Assumes a single 100 MHz clock domain.
package tpu_pkg;
   localparam int CNT_W = 16;
   localparam int NUM_CH = 2;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_FULL = 16'hFFFF;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam int SIGN_BIT = 15;
   localparam logic [1:0] CLK_NONE = 2'h0;
   localparam logic [1:0] CLK_BUS = 2'h1;
   localparam logic [1:0] CLK_FIXED = 2'h2;
   localparam logic [1:0] CLK_EXT = 2'h3;
   localparam logic [2:0] PRESCALE_RESET = 3'h0;
   // Channel modes from mode_select_b:a when not center aligned
   localparam logic [1:0] MODE_CAPTURE = 2'h0;
   localparam logic [1:0] MODE_COMPARE = 2'h1;
   // Compare pin actions from edge_level_select_b:a
   localparam logic [1:0] OC_NONE = 2'h0;
   localparam logic [1:0] OC_TOGGLE = 2'h1;
   localparam logic [1:0] OC_CLEAR = 2'h2;
   localparam logic [1:0] OC_SET = 2'h3;
endpackage

// *** include/tick_if.sv ***
// Counter tick and state bundle shared between counter and channels.
// Assumes all members are driven in the clock domain of the timer.
`timescale 1ns/1ps
interface tick_if;
   logic tick;
   logic [15:0] count;
   logic [15:0] modulus;
   logic up;
   logic center;
   logic clk_on;
   logic load_point;
   modport counter (output tick, count, modulus, up, center, clk_on, load_point);
   modport channel (input tick, count, modulus, up, center, clk_on, load_point);
endinterface

// *** logic/pwm_channel.sv ***
// One timer channel: value buffer, compare, PWM pin and event flag.
// Assumes tick and counter state from the counter side in the same domain.
`timescale 1ns/1ps
module pwm_channel (
   input wire logic clock,
   input wire logic reset_n,
   tick_if.channel t,
   input wire logic csc_write,
   input wire logic [5:0] csc_data,
   input wire logic val_high_write,
   input wire logic val_low_write,
   input wire logic [7:0] val_data,
   input wire logic flag_read,
   output logic [5:0] csc_r,
   output logic [15:0] value_r,
   output logic flag_r,
   output logic pin_r,
   output logic pin_oe_r,
   output logic irq_r
);
   // csc: [5]=irq_enable [4]=mode_b [3]=mode_a [2]=edge_b [1]=edge_a [0]=flag write bit
   logic [5:0] csc_nxt;
   logic [15:0] value_nxt, buf_r, buf_nxt;
   logic hi_seen_r, hi_seen_nxt, lo_seen_r, lo_seen_nxt, pend_r, pend_nxt;
   logic flag_nxt, armed_r, armed_nxt, pin_nxt, pin_oe_nxt, irq_nxt;
   logic match, event_now, edge_pwm, oc_mode;

   assign oc_mode = !t.center && csc_r[4:3] == tpu_pkg::MODE_COMPARE;
   assign edge_pwm = !t.center && csc_r[4];
   assign match = t.tick && t.count == value_r && (oc_mode || edge_pwm || t.center);
   assign event_now = match;

   always_comb begin
      csc_nxt = csc_r;
      buf_nxt = buf_r;
      value_nxt = value_r;
      hi_seen_nxt = hi_seen_r;
      lo_seen_nxt = lo_seen_r;
      pend_nxt = pend_r;
      flag_nxt = flag_r;
      armed_nxt = armed_r;
      pin_nxt = pin_r;
      if (csc_write) begin
         csc_nxt = {csc_data[5:1], 1'b0};
         hi_seen_nxt = 1'b0;
         lo_seen_nxt = 1'b0;
         pend_nxt = 1'b0;
      end else begin
         if (val_high_write) begin
            buf_nxt[15:8] = val_data;
            hi_seen_nxt = 1'b1;
         end
         if (val_low_write) begin
            buf_nxt[7:0] = val_data;
            lo_seen_nxt = 1'b1;
         end
         if (hi_seen_nxt && lo_seen_nxt) begin
            hi_seen_nxt = 1'b0;
            lo_seen_nxt = 1'b0;
            if (!t.clk_on)
               value_nxt = buf_nxt;
            else
               pend_nxt = 1'b1;
         end
      end
      // compare loads on next tick; PWM loads at modulus step
      if (pend_r && t.tick && (oc_mode || csc_r[4:3] == tpu_pkg::MODE_CAPTURE && !t.center
            ? 1'b1 : t.load_point)) begin
         value_nxt = buf_r;
         pend_nxt = 1'b0;
      end
      // read arms, zero write clears, new event wins
      if (flag_read && flag_r)
         armed_nxt = 1'b1;
      if (csc_write && !csc_data[0] && armed_r)
         flag_nxt = 1'b0;
      if (csc_write)
         armed_nxt = 1'b0;
      if (event_now) begin
         flag_nxt = 1'b1;
         armed_nxt = 1'b0;
      end
      if (t.center) begin
         // zero or negative value never active
         if (value_r == tpu_pkg::CNT_ZERO || value_r[tpu_pkg::SIGN_BIT])
            pin_nxt = csc_r[1];
         // up match inactive, down match active
         else if (match)
            pin_nxt = t.up ? csc_r[1] : !csc_r[1];
         else if (t.tick && t.count == tpu_pkg::CNT_ZERO && value_r > t.modulus)
            pin_nxt = !csc_r[1];
      end else if (edge_pwm) begin
         if (value_r == tpu_pkg::CNT_ZERO)
            pin_nxt = csc_r[1];
         else if (match)
            pin_nxt = csc_r[1];
         else if (t.tick && t.count == tpu_pkg::CNT_ZERO)
            pin_nxt = !csc_r[1];
      end else if (oc_mode && match) begin
         case (csc_r[2:1])
            tpu_pkg::OC_TOGGLE: pin_nxt = !pin_r;
            tpu_pkg::OC_CLEAR: pin_nxt = 1'b0;
            tpu_pkg::OC_SET: pin_nxt = 1'b1;
            default: pin_nxt = pin_r;
         endcase
      end
      pin_oe_nxt = t.center || csc_r[4] || (csc_r[3] && csc_r[2:1] != tpu_pkg::OC_NONE);
      irq_nxt = csc_nxt[5] && flag_nxt;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         csc_r <= 6'h00;
         value_r <= 16'h0000;
         buf_r <= 16'h0000;
         hi_seen_r <= 1'b0;
         lo_seen_r <= 1'b0;
         pend_r <= 1'b0;
         flag_r <= 1'b0;
         armed_r <= 1'b0;
         pin_r <= 1'b0;
         pin_oe_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         csc_r <= csc_nxt;
         value_r <= value_nxt;
         buf_r <= buf_nxt;
         hi_seen_r <= hi_seen_nxt;
         lo_seen_r <= lo_seen_nxt;
         pend_r <= pend_nxt;
         flag_r <= flag_nxt;
         armed_r <= armed_nxt;
         pin_r <= pin_nxt;
         pin_oe_r <= pin_oe_nxt;
         irq_r <= irq_nxt;
      end
   end
endmodule

// *** logic/timer_compare_pwm_channels.sv ***
// Function
// - Compare match sets, clears or toggles pin
// - Compare value loads after both bytes
// - Compare match sets channel flag
// - Edge PWM up counts, period modulus+1
// - Edge level selects overflow/compare polarity
// - Zero gives 0%, above modulus 100%
// - Edge PWM loads at modulus step
// - Center PWM counts up and down
// - Center zero/negative 0%, above modulus 100%
// - Center up match low, down high
// - Byte writes land in buffers
// - Center PWM loads at modulus step
// - Center overflow at end of modulus
// - Main control write drops modulus bytes
// - Channel control write drops value bytes
// - Reset clears control, releases pins
// - Every match sets channel flag
// - Interrupts are level, flag and enable
// - Flags clear by read then zero write
// - Clock select: none, bus, fixed, external
// - Up mode overflow at terminal wrap
// - Up/down ends last one tick
// Timer counter, modulus, overflow flag and two channels.
// Assumes byte strobes are one-cycle pulses in the clock domain.
`timescale 1ns/1ps
module timer_compare_pwm_channels (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic msc_write,
   input wire logic [7:0] msc_data,
   input wire logic msc_read,
   input wire logic mod_high_write,
   input wire logic mod_low_write,
   input wire logic [7:0] mod_data,
   input wire logic count_write,
   input wire logic fixed_clock_en,
   input wire logic ext_clock_pin,
   input wire logic [1:0] csc_write,
   input wire logic [11:0] csc_data,
   input wire logic [1:0] val_high_write,
   input wire logic [1:0] val_low_write,
   input wire logic [15:0] val_data,
   input wire logic [1:0] flag_read,
   output logic [7:0] msc_r,
   output logic [15:0] count_r,
   output logic [15:0] modulus_r,
   output logic overflow_irq_r,
   output logic [1:0] channel_irq_r,
   output logic [1:0] channel_pin_r,
   output logic [1:0] channel_pin_oe_r,
   output logic [11:0] channel_csc_r,
   output logic [31:0] channel_value_r,
   output logic [1:0] channel_flag_r
);
   // msc: [7]=overflow flag [6]=irq enable [5]=center [4:3]=clock select [2:0]=prescale
   tick_if t ();
   logic [7:0] msc_nxt;
   logic [15:0] count_nxt, modulus_nxt, mbuf_r, mbuf_nxt;
   logic mhi_r, mhi_nxt, mlo_r, mlo_nxt, up_r, up_nxt, armed_r, armed_nxt;
   logic [6:0] pre_r, pre_nxt;
   logic ext_s1_r, ext_s2_r, ext_s3_r;
   logic src_tick, tick, terminal, overflow, irq_nxt;
   logic [15:0] term;

   function automatic logic [6:0] pre_limit(input logic [2:0] ps);
      pre_limit = 7'((8'h01 << ps) - 8'h01);
   endfunction

   // Pin clock passes two flops; third only for edge detect
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end else begin
         ext_s1_r <= ext_clock_pin;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   always_comb begin
      case (msc_r[4:3])
         tpu_pkg::CLK_BUS: src_tick = 1'b1;
         tpu_pkg::CLK_FIXED: src_tick = fixed_clock_en;
         tpu_pkg::CLK_EXT: src_tick = ext_s2_r && !ext_s3_r;
         default: src_tick = 1'b0;
      endcase
   end

   assign tick = src_tick && pre_r == pre_limit(msc_r[2:0]);
   assign term = modulus_r == tpu_pkg::CNT_ZERO ? tpu_pkg::CNT_FULL : modulus_r;
   assign terminal = count_r == term;
   assign overflow = tick && terminal && (!msc_r[5] || up_r);

   assign t.tick = tick;
   assign t.count = count_r;
   assign t.modulus = modulus_r;
   assign t.up = up_r;
   assign t.center = msc_r[5];
   assign t.clk_on = msc_r[4:3] != tpu_pkg::CLK_NONE;
   // step into terminal count
   // Only the upward step counts; the down pass also crosses terminal-1
   assign t.load_point = count_r == 16'(term - tpu_pkg::CNT_ONE) && (!msc_r[5] || up_r);

   always_comb begin
      msc_nxt = msc_r;
      count_nxt = count_r;
      modulus_nxt = modulus_r;
      mbuf_nxt = mbuf_r;
      mhi_nxt = mhi_r;
      mlo_nxt = mlo_r;
      up_nxt = up_r;
      armed_nxt = armed_r;
      pre_nxt = pre_r;
      if (src_tick)
         pre_nxt = tick ? 7'h00 : 7'(pre_r + 7'h01);
      if (tick) begin
         if (!msc_r[5]) begin
            count_nxt = terminal ? tpu_pkg::CNT_ZERO : 16'(count_r + tpu_pkg::CNT_ONE);
            up_nxt = 1'b1;
         end else if (up_r) begin
            // turn after terminal lasts one tick
            if (terminal) begin
               up_nxt = 1'b0;
               count_nxt = 16'(count_r - tpu_pkg::CNT_ONE);
            end else
               count_nxt = 16'(count_r + tpu_pkg::CNT_ONE);
         end else if (count_r == tpu_pkg::CNT_ZERO) begin
            up_nxt = 1'b1;
            count_nxt = tpu_pkg::CNT_ONE;
         end else
            count_nxt = 16'(count_r - tpu_pkg::CNT_ONE);
      end
      if (count_write) begin
         count_nxt = tpu_pkg::CNT_ZERO;
         pre_nxt = 7'h00;
         up_nxt = 1'b1;
      end
      if (msc_write) begin
         msc_nxt = {msc_r[7], msc_data[6:0]};
         mhi_nxt = 1'b0;
         mlo_nxt = 1'b0;
      end else begin
         if (mod_high_write) begin
            mbuf_nxt[15:8] = mod_data;
            mhi_nxt = 1'b1;
         end
         if (mod_low_write) begin
            mbuf_nxt[7:0] = mod_data;
            mlo_nxt = 1'b1;
         end
         if (mhi_nxt && mlo_nxt) begin
            modulus_nxt = mbuf_nxt;
            mhi_nxt = 1'b0;
            mlo_nxt = 1'b0;
         end
      end
      if (msc_read && msc_r[7])
         armed_nxt = 1'b1;
      if (msc_write && !msc_data[7] && armed_r)
         msc_nxt[7] = 1'b0;
      if (msc_write)
         armed_nxt = 1'b0;
      if (overflow) begin
         msc_nxt[7] = 1'b1;
         armed_nxt = 1'b0;
      end
      irq_nxt = msc_nxt[6] && msc_nxt[7];
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         msc_r <= 8'h00;
         count_r <= 16'h0000;
         modulus_r <= 16'h0000;
         mbuf_r <= 16'h0000;
         mhi_r <= 1'b0;
         mlo_r <= 1'b0;
         up_r <= 1'b1;
         armed_r <= 1'b0;
         pre_r <= 7'h00;
         overflow_irq_r <= 1'b0;
      end else begin
         msc_r <= msc_nxt;
         count_r <= count_nxt;
         modulus_r <= modulus_nxt;
         mbuf_r <= mbuf_nxt;
         mhi_r <= mhi_nxt;
         mlo_r <= mlo_nxt;
         up_r <= up_nxt;
         armed_r <= armed_nxt;
         pre_r <= pre_nxt;
         overflow_irq_r <= irq_nxt;
      end
   end

   for (genvar i = 0; i < tpu_pkg::NUM_CH; i++) begin : ch
      pwm_channel u_ch (
         .clock(clock),
         .reset_n(reset_n),
         .t(t.channel),
         .csc_write(csc_write[i]),
         .csc_data(csc_data[i*6 +: 6]),
         .val_high_write(val_high_write[i]),
         .val_low_write(val_low_write[i]),
         .val_data(val_data[i*8 +: 8]),
         .flag_read(flag_read[i]),
         .csc_r(channel_csc_r[i*6 +: 6]),
         .value_r(channel_value_r[i*16 +: 16]),
         .flag_r(channel_flag_r[i]),
         .pin_r(channel_pin_r[i]),
         .pin_oe_r(channel_pin_oe_r[i]),
         .irq_r(channel_irq_r[i])
      );
   end
endmodule

// *** testbench/timer_compare_pwm_channels_assertions.sv ***
// Port-level checks for the timer compare/PWM block.
// Assumes one clock domain and byte strobes one cycle wide.
`timescale 1ns/1ps
module timer_pwm_checker (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic msc_write,
   input wire logic [7:0] msc_data,
   input wire logic mod_high_write,
   input wire logic mod_low_write,
   input wire logic [7:0] mod_data,
   input wire logic [1:0] csc_write,
   input wire logic [1:0] val_high_write,
   input wire logic [1:0] val_low_write,
   input wire logic [15:0] val_data,
   input wire logic [7:0] msc_r,
   input wire logic [15:0] count_r,
   input wire logic [15:0] modulus_r,
   input wire logic overflow_irq_r,
   input wire logic [1:0] channel_irq_r,
   input wire logic [1:0] channel_pin_oe_r,
   input wire logic [11:0] channel_csc_r,
   input wire logic [31:0] channel_value_r,
   input wire logic [1:0] channel_flag_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence s_mod_pair;
      mod_high_write && !msc_write ##1 mod_low_write && !msc_write;
   endsequence
   sequence s_val_pair;
      val_high_write[0] && !csc_write[0] ##1 val_low_write[0] && !csc_write[0];
   endsequence
   a_reset_clears: assert property ($rose(reset_n) |-> msc_r == 8'h00 &&
      channel_csc_r == 12'h000 && channel_pin_oe_r == 2'h0)
      else $error("control not cleared by reset");
   a_ovf_irq_level: assert property (overflow_irq_r == (msc_r[7] && msc_r[6]))
      else $error("overflow irq not flag and enable");
   a_ch_irq_level: assert property (channel_irq_r ==
      (channel_flag_r & {channel_csc_r[11], channel_csc_r[5]}))
      else $error("channel irq not flag and enable");
   a_mod_pair_load: assert property (s_mod_pair |=>
      modulus_r == {$past(mod_data, 2), $past(mod_data)})
      else $error("modulus pair not loaded");
   a_flag_clear_write: assert property ($fell(msc_r[7]) |->
      $past(msc_write) && !$past(msc_data[7]))
      else $error("overflow flag cleared without zero write");
   // Either edge of the flag update is accepted; both follow the wrap
   a_ovf_at_wrap: assert property (!msc_r[5] && $rose(msc_r[7]) |->
      count_r == tpu_pkg::CNT_ZERO || $past(count_r) == tpu_pkg::CNT_ZERO)
      else $error("overflow flag away from wrap");
   a_pin_drive: assert property ($stable(msc_r) && $stable(channel_csc_r) |->
      channel_pin_oe_r[0] == (msc_r[5] || channel_csc_r[4] ||
      (channel_csc_r[3] && channel_csc_r[2:1] != tpu_pkg::OC_NONE)))
      else $error("pin drive enable wrong for mode");
   a_cmp_flag: assert property (!msc_r[5] &&
      channel_csc_r[10:9] == tpu_pkg::MODE_COMPARE && $changed(count_r) &&
      count_r == channel_value_r[31:16] |-> ##[0:1] channel_flag_r[1])
      else $error("compare match did not set flag");
   a_val_pair_idle: assert property (s_val_pair ##0 (msc_r[4:3] == tpu_pkg::CLK_NONE &&
      channel_csc_r[4:3] != tpu_pkg::MODE_CAPTURE) |=>
      channel_value_r[15:0] == {$past(val_data[7:0], 2), $past(val_data[7:0])})
      else $error("value pair not loaded with clock off");
endmodule

bind timer_compare_pwm_channels timer_pwm_checker i_timer_pwm_checker (.clock, .reset_n,
   .msc_write, .msc_data, .mod_high_write, .mod_low_write, .mod_data, .csc_write,
   .val_high_write, .val_low_write, .val_data, .msc_r, .count_r, .modulus_r,
   .overflow_irq_r, .channel_irq_r, .channel_pin_oe_r, .channel_csc_r,
   .channel_value_r, .channel_flag_r);

// *** testbench/pin_load.sv ***
// Load on a timer channel pin: counts cycles the pin sits high.
// Assumes a pull-down on the pin while the timer releases it.
`timescale 1ns/1ps
module pin_load (
   input wire logic clock,
   input wire logic clr,
   input wire logic pin,
   input wire logic oe,
   output logic [15:0] high_cnt
);
   logic level;
   // Released pin falls to the pull-down, never keeps the last value
   assign level = oe ? pin : 1'b0;
   always_ff @(posedge clock) begin
      high_cnt <= clr ? 16'h0000 : high_cnt + 16'(level);
   end
endmodule

// *** testbench/tb_timer_compare_pwm_channels.sv ***
// Self-checking bench for the timer compare/PWM block.
// Assumes the bus clock for duty checks; fixed and pin clocks only counted.
`timescale 1ns/1ps
module tb_timer_compare_pwm_channels;
   logic clock = 1'b0, reset_n = 1'b0, clr = 1'b0, p;
   logic msc_write = 1'b0, msc_read = 1'b0, mod_high_write = 1'b0, mod_low_write = 1'b0;
   logic count_write = 1'b0, fixed_clock_en = 1'b0, ext_clock_pin = 1'b0;
   logic [7:0] msc_data = 8'h00, mod_data = 8'h00, msc_r;
   logic [1:0] csc_write = 2'h0, val_high_write = 2'h0, val_low_write = 2'h0;
   logic [1:0] flag_read = 2'h0, channel_irq_r, channel_pin_r;
   logic [1:0] channel_pin_oe_r, channel_flag_r;
   logic [11:0] csc_data = 12'h000, channel_csc_r;
   logic [15:0] val_data = 16'h0000, count_r, modulus_r, high_cnt;
   logic [31:0] channel_value_r;
   logic overflow_irq_r;
   logic [15:0] cval [4] = '{16'h0004, 16'h8004, 16'h000A, 16'h0000};
   logic [15:0] cexp [4] = '{16'h0010, 16'h0000, 16'h0024, 16'h0000};
   int fails = 0, samples_checked = 0;
   timer_compare_pwm_channels i_timer_compare_pwm_channels (.clock, .reset_n, .msc_write,
      .msc_data, .msc_read, .mod_high_write, .mod_low_write, .mod_data, .count_write,
      .fixed_clock_en, .ext_clock_pin, .csc_write, .csc_data, .val_high_write,
      .val_low_write, .val_data, .flag_read, .msc_r, .count_r, .modulus_r, .overflow_irq_r,
      .channel_irq_r, .channel_pin_r, .channel_pin_oe_r, .channel_csc_r, .channel_value_r,
      .channel_flag_r);
   pin_load i_pin_load (.clock, .clr, .pin(channel_pin_r[0]), .oe(channel_pin_oe_r[0]),
      .high_cnt);
   always #5 clock = ~clock;
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   task automatic wr_msc(input logic [7:0] d);
      msc_data = d;
      msc_write = 1'b1;
      cyc(1);
      msc_write = 1'b0;
      cyc(1);
   endtask
   task automatic wr_mod(input logic [7:0] h, input logic [7:0] l);
      mod_data = h;
      mod_high_write = 1'b1;
      cyc(1);
      mod_high_write = 1'b0;
      mod_data = l;
      mod_low_write = 1'b1;
      cyc(1);
      mod_low_write = 1'b0;
      cyc(1);
   endtask
   task automatic wr_csc(input int ch, input logic [5:0] d);
      csc_data = {d, d};
      csc_write[ch] = 1'b1;
      cyc(1);
      csc_write = 2'h0;
      cyc(1);
   endtask
   task automatic wr_val(input int ch, input logic [15:0] v);
      val_data = {2{v[15:8]}};
      val_high_write[ch] = 1'b1;
      cyc(1);
      val_high_write = 2'h0;
      val_data = {2{v[7:0]}};
      val_low_write[ch] = 1'b1;
      cyc(1);
      val_low_write = 2'h0;
      cyc(1);
   endtask
   task automatic wait_cnt(input logic [15:0] c);
      for (int n = 0; n < 100 && count_r !== c; n++) cyc(1);
      // Running out of the limit is a mismatch
      chk(count_r, c);
   endtask
   task automatic meas(input int n, input logic [15:0] e);
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(n);
      chk(high_cnt, e);
   endtask
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Whole run is about 800 cycles
   initial begin
      #20000;
      fails++;
      stop_test();
   end
   initial begin
      cyc(6);
      reset_n = 1'b1;
      cyc(1);
      chk(16'(msc_r), 16'h0000);
      chk(16'(channel_csc_r), 16'h0000);
      chk(16'(channel_pin_oe_r), 16'h0000);
      done("reset");
      wr_mod(8'h00, 8'h09);
      chk(modulus_r, 16'h0009);
      mod_data = 8'h12;
      mod_high_write = 1'b1;
      cyc(1);
      mod_high_write = 1'b0;
      msc_write = 1'b1;
      cyc(1);
      msc_write = 1'b0;
      mod_low_write = 1'b1;
      cyc(1);
      mod_low_write = 1'b0;
      cyc(1);
      chk(modulus_r, 16'h0009);
      chk(count_r, 16'h0000);
      done("modulus");
      wr_csc(0, 6'h10);
      wr_val(0, 16'h0004);
      chk(channel_value_r[15:0], 16'h0004);
      wr_msc(8'h08);
      cyc(20);
      meas(50, 16'd20);
      wr_csc(0, 6'h12);
      cyc(20);
      meas(50, 16'd30);
      wr_csc(0, 6'h10);
      wait_cnt(16'h0001);
      wr_val(0, 16'h000A);
      chk(channel_value_r[15:0], 16'h0004);
      wait_cnt(16'h0009);
      chk(channel_value_r[15:0], 16'h000A);
      cyc(10);
      meas(50, 16'd50);
      wr_val(0, 16'h0000);
      cyc(20);
      meas(50, 16'd0);
      done("edge pwm");
      wr_msc(8'h48);
      cyc(12);
      chk(16'(msc_r[7]), 16'h0001);
      chk(16'(overflow_irq_r), 16'h0001);
      wr_msc(8'hC0);
      wr_msc(8'h40);
      chk(16'(msc_r[7]), 16'h0001);
      p = count_r[0];
      cyc(5);
      chk(16'(count_r[0]), 16'(p));
      msc_read = 1'b1;
      cyc(1);
      msc_read = 1'b0;
      wr_msc(8'h40);
      chk(16'(msc_r[7]), 16'h0000);
      chk(16'(overflow_irq_r), 16'h0000);
      count_write = 1'b1;
      cyc(1);
      count_write = 1'b0;
      cyc(1);
      chk(count_r, 16'h0000);
      done("overflow flag");
      wr_csc(1, 6'h2B);
      wr_val(1, 16'h0005);
      chk(channel_value_r[31:16], 16'h0005);
      p = channel_pin_r[1];
      wr_msc(8'h08);
      cyc(8);
      chk(16'(channel_flag_r[1]), 16'h0001);
      chk(16'(channel_irq_r[1]), 16'h0001);
      chk(16'(channel_pin_r[1]), 16'(!p));
      for (int a = 2; a < 4; a++) begin
         wr_csc(1, {3'b101, 2'(a), 1'b1});
         cyc(12);
         chk(16'(channel_pin_r[1]), 16'(a % 2));
      end
      wr_msc(8'h00);
      flag_read = 2'h2;
      cyc(1);
      flag_read = 2'h0;
      wr_csc(1, 6'h2A);
      chk(16'(channel_flag_r[1]), 16'h0000);
      done("compare");
      wr_csc(1, 6'h00);
      chk(16'(channel_pin_oe_r[1]), 16'h0000);
      wr_msc(8'h28);
      for (int i = 0; i < 4; i++) begin
         wr_val(0, cval[i]);
         cyc(40);
         meas(36, cexp[i]);
      end
      done("center pwm");
      wr_msc(8'h11);
      count_write = 1'b1;
      cyc(1);
      count_write = 1'b0;
      fixed_clock_en = 1'b1;
      cyc(8);
      fixed_clock_en = 1'b0;
      cyc(1);
      chk(count_r, 16'h0004);
      wr_msc(8'h18);
      count_write = 1'b1;
      cyc(1);
      count_write = 1'b0;
      for (int e = 0; e < 3; e++) begin
         ext_clock_pin = 1'b1;
         cyc(2);
         ext_clock_pin = 1'b0;
         cyc(2);
      end
      cyc(3);
      chk(count_r, 16'h0003);
      done("clock sources");
      stop_test();
   end
endmodule
